/* rtl/ccs_pkg.sv */
// package: constants and types for the ccd readout clock sequencer
package ccs_pkg;

  // ***************************************************************
  // geometry
  // ***************************************************************
  localparam int CCS_FRAME_ROWS = 602;
  localparam int CCS_ROW_PIXELS = 640;
  localparam int CCS_OVERCLOCKS = 30;
  localparam int CCS_GUARD_PIXELS = 5;
  localparam int CCS_PATTERNS = 64;
  localparam int CCS_CLK_SETS = 4;
  localparam int CCS_SHIFTS_PER_PIXEL = 2;

  // ***************************************************************
  // pattern table layout
  // ***************************************************************
  localparam int CCS_PAT_W = $clog2(CCS_PATTERNS);
  localparam int CCS_CNT_W = 12;
  localparam logic [CCS_CNT_W-1:0] CCS_DEF_ROWS = 12'h100;
  localparam logic [CCS_CNT_W-1:0] CCS_DEF_DIV = 12'h004;

  // clock set indices
  localparam int CCS_SET_IMG = 0;
  localparam int CCS_SET_STO = 1;
  localparam int CCS_SET_RDA = 2;
  localparam int CCS_SET_RDB = 3;

  // one-hot three-phase step pattern: phase 1, 2, 3
  localparam logic [2:0] CCS_PH_IDLE = 3'h1;

  typedef struct packed {
    logic [CCS_CNT_W-1:0] rows;   // store rows read out per frame
    logic [CCS_CNT_W-1:0] div;    // phase step period in cycles
  } ccs_pattern_s;

  typedef struct packed {
    logic [2:0] img;
    logic [2:0] sto;
    logic [2:0] rda;
    logic [2:0] rdb;
  } ccs_phases_s;

  typedef struct packed {
    logic valid;
    logic overclock;
    logic guard;
  } ccs_pix_s;

  typedef enum logic [4:0] {
    CCS_IDLE  = 5'h01,
    CCS_FRAME = 5'h02,
    CCS_ROW   = 5'h04,
    CCS_PIXEL = 5'h08,
    CCS_DONE  = 5'h10
  } ccs_state_e;

endpackage : ccs_pkg

/* rtl/ccs_sequencer.sv */
// module: ccd clock sequencer for a frame-transfer imaging sensor
`timescale 1ns/1ps

module ccs_sequencer
  import ccs_pkg::*;
#(
  parameter int FRAME_ROWS = CCS_FRAME_ROWS,
  parameter int ROW_PIXELS = CCS_ROW_PIXELS,
  parameter int OVERCLOCKS = CCS_OVERCLOCKS,
  parameter int GUARD_PIXELS = CCS_GUARD_PIXELS,
  parameter int PATTERNS = CCS_PATTERNS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [CCS_PAT_W-1:0] i_mode,
  input wire logic i_load,
  input wire logic [CCS_PAT_W-1:0] i_load_index,
  input wire ccs_pattern_s i_load_pattern,
  output ccs_phases_s o_phases,
  output ccs_pix_s o_pix,
  output logic o_busy,
  output logic [CCS_PAT_W-1:0] o_active_mode
);

  // ***************************************************************
  // pattern storage
  // ***************************************************************
  ccs_pattern_s pattern [PATTERNS];
  ccs_pattern_s cur;
  ccs_state_e state;
  ccs_state_e next_state;

  // one decode line per slot; a load may land in any slot at any time
  logic [PATTERNS-1:0] load_hit;

  genvar g;
  generate
    for (g = 0; g < PATTERNS; g++) begin : g_pat
      assign load_hit[g] = i_load && (i_load_index == CCS_PAT_W'(g));
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          pattern[g] <= '{rows: CCS_DEF_ROWS, div: CCS_DEF_DIV};
        end else if (load_hit[g]) begin
          pattern[g] <= i_load_pattern;
        end
      end
    end
  endgenerate

  // ***************************************************************
  // phase step enable divider
  // ***************************************************************
  logic [CCS_CNT_W-1:0] div_cnt;
  wire div_zero = (cur.div == '0);
  wire step = (state != CCS_IDLE) && (div_cnt == '0);
  // limitation: a period of 0 or 1 both step every cycle
  wire [CCS_CNT_W-1:0] div_reload = div_zero ? '0 : cur.div - 12'h001;

  always_ff @(posedge i_clk) begin
    if (i_rst || state == CCS_IDLE || step) begin
      div_cnt <= div_reload;
    end else begin
      div_cnt <= div_cnt - 12'h001;
    end
  end

  // ***************************************************************
  // three-phase rotation; a full cycle is three steps
  // ***************************************************************
  logic [1:0] ph_step;
  wire cycle_end = step && (ph_step == 2'h2);

  always_ff @(posedge i_clk) begin
    if (i_rst || state == CCS_IDLE) begin
      ph_step <= 2'h0;
    end else if (step) begin
      ph_step <= cycle_end ? 2'h0 : ph_step + 2'h1;
    end
  end

  wire [2:0] ph_run = 3'h1 << ph_step;

  // ***************************************************************
  // counters
  // ***************************************************************
  logic [CCS_CNT_W-1:0] frame_cnt;
  logic [CCS_CNT_W-1:0] row_cnt;
  logic [CCS_CNT_W-1:0] pix_cnt;
  logic half;

  localparam logic [CCS_CNT_W-1:0] LAST_FRAME = CCS_CNT_W'(FRAME_ROWS - 1);
  localparam logic [CCS_CNT_W-1:0] LAST_PIX = CCS_CNT_W'(ROW_PIXELS - 1);
  localparam logic [CCS_CNT_W-1:0] FIRST_OC =
    CCS_CNT_W'(ROW_PIXELS - OVERCLOCKS);
  localparam logic [CCS_CNT_W-1:0] GUARD_N = CCS_CNT_W'(GUARD_PIXELS);

  wire frame_last = cycle_end && frame_cnt == LAST_FRAME;
  // second readout cycle of a pixel closes it
  wire pix_end = cycle_end && state == CCS_PIXEL && half;
  wire row_last = pix_end && pix_cnt == LAST_PIX;
  // a row count of zero wraps to the full counter range
  wire rows_done = row_cnt == cur.rows - 12'h001;

  // ***************************************************************
  // frame, row and pixel sequencing
  // ***************************************************************
  // starts are taken only while idle; later ones are dropped
  wire start_ok = (state == CCS_IDLE) && i_start;
  wire frame_inc = (state == CCS_FRAME) && cycle_end;
  wire half_flip = (state == CCS_PIXEL) && cycle_end;

  always_comb begin
    next_state = state;
    unique case (state)
      CCS_IDLE: if (start_ok) next_state = CCS_FRAME;
      CCS_FRAME: if (frame_last) next_state = CCS_ROW;
      CCS_ROW: if (cycle_end) next_state = CCS_PIXEL;
      // next row waits until all overclocks are out
      CCS_PIXEL: if (row_last) begin
        next_state = rows_done ? CCS_DONE : CCS_ROW;
      end
      // one settle cycle lets the last strobe and parked phases out
      CCS_DONE: next_state = CCS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= CCS_IDLE;
      cur <= '{rows: CCS_DEF_ROWS, div: CCS_DEF_DIV};
      o_active_mode <= '0;
    end else begin
      state <= next_state;
      // mode latched only at start; the first step wait of a frame still counts down the previous pattern's div
      if (start_ok) begin
        cur <= pattern[i_mode];
        o_active_mode <= i_mode;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || state == CCS_IDLE) begin
      frame_cnt <= '0;
      row_cnt <= '0;
      pix_cnt <= '0;
      half <= 1'b0;
    end else begin
      if (frame_inc) frame_cnt <= frame_cnt + 12'h001;
      if (half_flip) half <= ~half;
      if (pix_end) pix_cnt <= row_last ? '0 : pix_cnt + 12'h001;
      if (row_last) row_cnt <= row_cnt + 12'h001;
    end
  end

  // ***************************************************************
  // clock outputs; all sets share one step enable
  // ***************************************************************
  wire xfer = state == CCS_FRAME;
  wire rowsh = state == CCS_ROW;
  wire rdout = state == CCS_PIXEL;

  // no split mode: both readout sets share one enable
  logic [CCS_CLK_SETS-1:0] set_run;
  logic [2:0] set_ph [CCS_CLK_SETS];

  assign set_run[CCS_SET_IMG] = xfer;
  assign set_run[CCS_SET_STO] = xfer || rowsh;
  assign set_run[CCS_SET_RDA] = rdout;
  assign set_run[CCS_SET_RDB] = rdout;

  genvar s;
  generate
    for (s = 0; s < CCS_CLK_SETS; s++) begin : g_set
      // a stopped set parks on phase 1 while other sets move
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          set_ph[s] <= CCS_PH_IDLE;
        end else begin
          set_ph[s] <= set_run[s] ? ph_run : CCS_PH_IDLE;
        end
      end
    end
  endgenerate

  assign o_phases = '{
    img: set_ph[CCS_SET_IMG],
    sto: set_ph[CCS_SET_STO],
    rda: set_ph[CCS_SET_RDA],
    rdb: set_ph[CCS_SET_RDB]
  };

  // ***************************************************************
  // pixel strobe to the video chain
  // ***************************************************************
  // flags travel with valid so the video chain needs no counter
  wire next_guard = pix_end && (pix_cnt < GUARD_N);
  wire next_over = pix_end && (pix_cnt >= FIRST_OC);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pix <= '0;
    end else begin
      o_pix.valid <= pix_end;
      o_pix.guard <= next_guard;
      o_pix.overclock <= next_over;
    end
  end

  assign o_busy = state != CCS_IDLE;

endmodule : ccs_sequencer

/* verif/ccs_sequencer_sva.sv */
// checker: port-level assertions for the clock sequencer
`timescale 1ns/1ps
module ccs_sequencer_sva
  import ccs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [CCS_PAT_W-1:0] i_mode,
  input wire ccs_phases_s o_phases,
  input wire ccs_pix_s o_pix,
  input wire logic o_busy,
  input wire logic [CCS_PAT_W-1:0] o_active_mode
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_rd_same_dir: assert property (
    o_phases.rda == o_phases.rdb)
    else $error("readout sets differ");
  a_phase_one_hot: assert property (
    $onehot(o_phases.img) && $onehot(o_phases.sto) &&
    $onehot(o_phases.rda) && $onehot(o_phases.rdb))
    else $error("phase not one-hot");
  a_frame_lock: assert property (
    $changed(o_phases.img) |-> $changed(o_phases.sto) &&
    $stable(o_phases.rda))
    else $error("image moved without store");
  a_pix_spacing: assert property (
    o_pix.valid |=> !o_pix.valid [*5])
    else $error("pixels too close");
  a_flag_valid: assert property (
    (o_pix.guard || o_pix.overclock) |->
    o_pix.valid && !(o_pix.guard && o_pix.overclock))
    else $error("bad pixel flags");
  a_mode_taken: assert property (
    i_start && !o_busy |=> o_busy && o_active_mode == $past(i_mode))
    else $error("start lost");
  a_idle_still: assert property (
    !o_busy && !$past(o_busy) |-> $stable(o_phases) && !o_pix.valid)
    else $error("moved while idle");
  a_busy_mode: assert property (
    o_busy && $past(o_busy) |-> $stable(o_active_mode))
    else $error("mode changed mid-frame");
endmodule : ccs_sequencer_sva

bind ccs_sequencer ccs_sequencer_sva u_sva (.i_clk(i_clk), .i_rst(i_rst),
  .i_start(i_start), .i_mode(i_mode), .o_phases(o_phases), .o_pix(o_pix),
  .o_busy(o_busy), .o_active_mode(o_active_mode));

/* verif/ccs_ccd_model.sv */
// partner: sensor side that counts clock steps and pixels
`timescale 1ns/1ps
module ccs_ccd_model
  import ccs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_clr,
  input wire ccs_phases_s i_phases,
  input wire ccs_pix_s i_pix,
  output int o_cnt [6]
);
  ccs_phases_s last;
  // counts: image, store, readout steps, pixels, guard, overclock
  always_ff @(posedge i_clk) begin
    last <= i_phases;
    if (i_clr) begin
      o_cnt <= '{default: 0};
    end else begin
      o_cnt[0] <= o_cnt[0] + int'(i_phases.img != last.img);
      o_cnt[1] <= o_cnt[1] + int'(i_phases.sto != last.sto);
      o_cnt[2] <= o_cnt[2] + int'(i_phases.rda != last.rda);
      o_cnt[3] <= o_cnt[3] + int'(i_pix.valid);
      o_cnt[4] <= o_cnt[4] + int'(i_pix.guard);
      o_cnt[5] <= o_cnt[5] + int'(i_pix.overclock);
    end
  end
endmodule : ccs_ccd_model

/* verif/ccs_sequencer_bench.sv */
// bench: frame runs on a shortened sensor geometry
`timescale 1ns/1ps
module ccs_sequencer_bench;
  import ccs_pkg::*;
  logic clk, rst, start, load, clr, busy;
  logic [5:0] mode, idx, amode;
  ccs_pattern_s pat;
  ccs_phases_s ph;
  ccs_pix_s pix;
  int cnt [6];
  int bad_count = 0;
  int num_checks = 0;
  ccs_sequencer #(.FRAME_ROWS(4), .ROW_PIXELS(12), .OVERCLOCKS(3),
    .GUARD_PIXELS(2)) u_ccs_sequencer (.i_clk(clk), .i_rst(rst),
    .i_start(start), .i_mode(mode), .i_load(load), .i_load_index(idx),
    .i_load_pattern(pat), .o_phases(ph), .o_pix(pix), .o_busy(busy),
    .o_active_mode(amode));
  ccs_ccd_model u_ccs_ccd_model (.i_clk(clk), .i_clr(clr), .i_phases(ph),
    .i_pix(pix), .o_cnt(cnt));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic summarize;
    if (bad_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic put(input logic [5:0] i, input logic [11:0] r, d);
    @(negedge clk);
    load = 1'b1; idx = i; pat = '{rows: r, div: d};
    @(negedge clk);
    load = 1'b0;
  endtask : put
  // a second start and a reload of the running slot mid-frame are ignored
  task automatic run(input logic [5:0] m, input bit poke);
    int n;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0; start = 1'b1; mode = m;
    @(negedge clk);
    start = 1'b0;
    if (poke) begin
      repeat (20) @(negedge clk);
      start = 1'b1; mode = 6'h05;
      put(m, 12'h003, 12'h000);
      start = 1'b0;
    end
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    check(n < 5000, 1);
    if (n >= 5000) summarize();
    // the model counts the last parked phase one edge after busy drops
    repeat (2) @(negedge clk);
    check(amode, m);
  endtask : run
  // rows=2: two rows of 12 pixel periods after a 4-row transfer
  task automatic two_rows;
    put(6'h05, 12'h002, 12'h000);
    run(6'h05, 1'b0);
    check(cnt[0], 12);
    check(cnt[1], 18);
    check(cnt[2], 144);
    check(cnt[3], 24);
    check(cnt[4], 4);
    check(cnt[5], 6);
  endtask : two_rows
  // period 1 steps every cycle, one row, with interference mid-frame
  task automatic one_row_poked;
    put(6'h07, 12'h001, 12'h001);
    run(6'h07, 1'b1);
    check(cnt[1], 15);
    check(cnt[2], 72);
    check(cnt[3], 12);
  endtask : one_row_poked
  initial begin
    rst = 1'b1; start = 1'b0; load = 1'b0; clr = 1'b1;
    mode = 6'h00; idx = 6'h00; pat = '0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    two_rows();
    one_row_poked();
    summarize();
  end
endmodule : ccs_sequencer_bench
